// File: esc_pkg.sv
// shared constants and types of the echo speech comparators
package esc_pkg;
  localparam int CLOCK_PERIOD_NS = 10;
  // decay and hold time base, 0.1 ms
  localparam int TICK_PERIOD_NS = 100000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int TICK_W = 16;
  localparam int NUM_CH = 2;
  localparam int CH_ACOUSTIC = 0;
  localparam int CH_LINE = 1;
  localparam int LEVEL_W = 8;
  localparam int GAIN_W = 8;
  localparam int SLOPE_W = 8;
  localparam int HOLD_W = 16;
  localparam int TGT_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [LEVEL_W-1:0] esc_level_t;
  typedef logic signed [GAIN_W-1:0] esc_gain_t;
  typedef logic [SLOPE_W-1:0] esc_slope_t;
  typedef logic [HOLD_W-1:0] esc_hold_t;

  localparam esc_level_t LEVEL_MAX = 8'hFF;
  localparam esc_slope_t SLOPE_START = 8'h01;

  // reset values: gains in dB, slopes in 0.1 ms per dB, hold in 0.1 ms
  localparam esc_gain_t AE_GAIN_RST = 8'h00;
  localparam esc_gain_t AE_DELTA_RST = 8'h06;
  localparam esc_slope_t AE_SLOPE_RST = 8'h55;
  localparam esc_gain_t LE_GAIN_RST = 8'hF6;
  localparam esc_gain_t LE_DELTA_RST = 8'h0C;
  localparam esc_slope_t LE_SLOPE_RST = 8'hD5;
  localparam esc_hold_t HOLD_RST = 16'h0000;

  // register map
  localparam logic [ADDR_W-1:0] REG_AE_GAINS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_AE_TIMES = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LE_GAINS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LE_TIMES = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

  // field positions
  localparam int F_GAIN_LSB = 0;
  localparam int F_DS_LSB = 8;
  localparam int F_DN_LSB = 16;
  localparam int F_SS_LSB = 0;
  localparam int F_SN_LSB = 8;
  localparam int F_HOLD_LSB = 16;
  localparam int ST_AE_TALK = 0;
  localparam int ST_LE_TALK = 1;
  localparam int ST_AE_SET = 2;
  localparam int ST_LE_SET = 3;
  localparam int ST_SPEECH_TX = 4;
  localparam int ST_SPEECH_RX = 5;

  localparam logic [DATA_W-1:0] GAINS_MASK = 32'h00FFFFFF;
  localparam logic [DATA_W-1:0] TIMES_MASK = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] AE_GAINS_RST = {8'h00, AE_DELTA_RST, AE_DELTA_RST, AE_GAIN_RST};
  localparam logic [DATA_W-1:0] AE_TIMES_RST = {HOLD_RST, AE_SLOPE_RST, AE_SLOPE_RST};
  localparam logic [DATA_W-1:0] LE_GAINS_RST = {8'h00, LE_DELTA_RST, LE_DELTA_RST, LE_GAIN_RST};
  localparam logic [DATA_W-1:0] LE_TIMES_RST = {HOLD_RST, LE_SLOPE_RST, LE_SLOPE_RST};
endpackage : esc_pkg

// File: esc_if.sv
// link between the comparator end and its controller
`timescale 1ns/1ps
interface esc_if;
  import esc_pkg::*;
  esc_gain_t acoustic_echo_gain;
  esc_gain_t acoustic_delta_gain_speech;
  esc_gain_t acoustic_delta_gain_noise;
  esc_slope_t acoustic_decay_slope_speech;
  esc_slope_t acoustic_decay_slope_noise;
  esc_hold_t acoustic_echo_hold_time;
  esc_gain_t line_echo_gain;
  esc_gain_t line_delta_gain_speech;
  esc_gain_t line_delta_gain_noise;
  esc_slope_t line_decay_slope_speech;
  esc_slope_t line_decay_slope_noise;
  esc_hold_t line_echo_hold_time;
  logic speech_tx;
  logic speech_rx;
  logic acoustic_talk;
  logic line_talk;
  logic acoustic_speech_set;
  logic line_speech_set;

  modport dev (
    input acoustic_echo_gain, acoustic_delta_gain_speech, acoustic_delta_gain_noise,
    input acoustic_decay_slope_speech, acoustic_decay_slope_noise, acoustic_echo_hold_time,
    input line_echo_gain, line_delta_gain_speech, line_delta_gain_noise,
    input line_decay_slope_speech, line_decay_slope_noise, line_echo_hold_time,
    input speech_tx, speech_rx,
    output acoustic_talk, line_talk, acoustic_speech_set, line_speech_set
  );

  modport ctl (
    output acoustic_echo_gain, acoustic_delta_gain_speech, acoustic_delta_gain_noise,
    output acoustic_decay_slope_speech, acoustic_decay_slope_noise, acoustic_echo_hold_time,
    output line_echo_gain, line_delta_gain_speech, line_delta_gain_noise,
    output line_decay_slope_speech, line_decay_slope_noise, line_echo_hold_time,
    output speech_tx, speech_rx,
    input acoustic_talk, line_talk, acoustic_speech_set, line_speech_set
  );
endinterface : esc_if

// File: esc_dev.sv
// acoustic and line echo speech comparators
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// - acoustic comparator: speech and noise delta/slope
// - speech set entered only while speech recognized
// - speech set held for acoustic hold time
// - hold time matters only when sets differ
// - controller loads equal sets for single slope
// - programmable echo gain scales reference level
// - acoustic defaults 6 dB and 8.5 ms/dB
// - line comparator identical, own parameters
// - line echo gain default minus 10 dB
// - line defaults 12 dB and 21.3 ms/dB
// - line speech set held for line hold
// - slow slope, high delta cover long echoes
// - output set only above the characteristic
module esc_dev #(
  parameter int TICK_CYCLES_P = esc_pkg::TICK_CYCLES
) (
  // link to the controller
  esc_if.dev link,
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // log domain signal levels, one sample per valid strobe
  input wire logic I_SAMPLE_VALID,
  input wire esc_pkg::esc_level_t I_SPK_LEVEL,
  input wire esc_pkg::esc_level_t I_MIC_LEVEL,
  input wire esc_pkg::esc_level_t I_SEND_LEVEL,
  input wire esc_pkg::esc_level_t I_LINE_LEVEL,
  // decisions
  output logic O_ACOUSTIC_TALK,
  output logic O_LINE_TALK,
  output logic O_ACOUSTIC_SPEECH_SET,
  output logic O_LINE_SPEECH_SET
);
  import esc_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);

  // shared time base for decay and hold, one pulse per tick period
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  wire tick_wrap = (tick_cnt == TICK_LAST);
  wire [TICK_W-1:0] next_tick_cnt = tick_wrap ? '0 : tick_cnt + 1'b1;

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_wrap;
    end
  end

  // per channel views of the link and the level inputs
  esc_level_t ref_lvl [NUM_CH];
  esc_level_t cmp_lvl [NUM_CH];
  esc_gain_t gain [NUM_CH];
  esc_gain_t dg_s [NUM_CH];
  esc_gain_t dg_n [NUM_CH];
  esc_slope_t sl_s [NUM_CH];
  esc_slope_t sl_n [NUM_CH];
  esc_hold_t hold_time [NUM_CH];
  logic speech [NUM_CH];
  wire [NUM_CH-1:0] talk;
  wire [NUM_CH-1:0] set;

  // acoustic: mic against speaker drive; line: line receive against send
  assign ref_lvl[CH_ACOUSTIC] = I_SPK_LEVEL;
  assign cmp_lvl[CH_ACOUSTIC] = I_MIC_LEVEL;
  assign ref_lvl[CH_LINE] = I_SEND_LEVEL;
  assign cmp_lvl[CH_LINE] = I_LINE_LEVEL;

  // programming of each comparator from the link
  assign gain[CH_ACOUSTIC] = link.acoustic_echo_gain;
  assign dg_s[CH_ACOUSTIC] = link.acoustic_delta_gain_speech;
  assign dg_n[CH_ACOUSTIC] = link.acoustic_delta_gain_noise;
  assign sl_s[CH_ACOUSTIC] = link.acoustic_decay_slope_speech;
  assign sl_n[CH_ACOUSTIC] = link.acoustic_decay_slope_noise;
  assign hold_time[CH_ACOUSTIC] = link.acoustic_echo_hold_time;
  assign gain[CH_LINE] = link.line_echo_gain;
  assign dg_s[CH_LINE] = link.line_delta_gain_speech;
  assign dg_n[CH_LINE] = link.line_delta_gain_noise;
  assign sl_s[CH_LINE] = link.line_decay_slope_speech;
  assign sl_n[CH_LINE] = link.line_decay_slope_noise;
  assign hold_time[CH_LINE] = link.line_echo_hold_time;
  // near end speech decides the acoustic set, far end speech the line set
  assign speech[CH_ACOUSTIC] = link.speech_tx;
  assign speech[CH_LINE] = link.speech_rx;

  // one comparator per channel, both built alike
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_cmp
    esc_hold_t hold_cnt;
    esc_level_t peak;
    esc_slope_t slope_cnt;
    logic speech_set;
    logic talk_q;

    // echo hold: reload on every speech cycle, count down in ticks afterwards
    wire hold_busy = (hold_cnt != '0);
    wire hold_dec = tick & hold_busy;
    wire esc_hold_t next_hold = speech[ch] ? hold_time[ch] :
                                hold_dec ? hold_cnt - 1'b1 :
                                hold_cnt;
    wire next_speech_set = speech[ch] | hold_busy;

    // with equal sets the selection, and so the hold, has no effect
    wire esc_gain_t delta = speech_set ? dg_s[ch] : dg_n[ch];
    wire esc_slope_t slope = speech_set ? sl_s[ch] : sl_n[ch];

    // scaled reference plus delta; gain and delta are signed and sign extended
    wire [TGT_W-1:0] ref_ext = TGT_W'({1'b0, ref_lvl[ch]});
    wire [TGT_W-1:0] gain_ext = TGT_W'(gain[ch]);
    wire [TGT_W-1:0] delta_ext = TGT_W'(delta);
    wire [TGT_W-1:0] sum = ref_ext + gain_ext + delta_ext;
    // clamp into the level range instead of wrapping
    wire sum_neg = sum[TGT_W-1];
    wire sum_over = (sum[TGT_W-2:LEVEL_W] != '0);
    wire esc_level_t target = sum_neg ? '0 :
                              sum_over ? LEVEL_MAX :
                              sum[LEVEL_W-1:0];

    // a new peak starts a fresh decay of one dB every slope ticks
    wire rise = I_SAMPLE_VALID & (target > peak);
    // eight bit slope allows up to 25.5 ms per dB
    wire slope_due = tick & (slope_cnt >= slope);
    // peak stops at zero rather than wrapping to full scale
    wire peak_dec = slope_due & (peak != '0);
    wire esc_level_t next_peak = rise ? target :
                                 peak_dec ? peak - 1'b1 :
                                 peak;
    wire slope_restart = rise | slope_due;
    wire esc_slope_t next_slope_cnt = slope_restart ? SLOPE_START :
                                      tick ? slope_cnt + 1'b1 :
                                      slope_cnt;

    // characteristic is the higher of the fresh target and the decaying peak
    wire esc_level_t thresh = (target > peak) ? target : peak;
    // levels at or below the characteristic count as echo; talk moves only with a sample
    wire next_talk = I_SAMPLE_VALID ? (cmp_lvl[ch] > thresh) : talk_q;

    // comparator state, cleared by reset except the slope count, which reset loads with SLOPE_START
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        hold_cnt <= '0;
      end else begin
        hold_cnt <= next_hold;
      end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        speech_set <= 1'b0;
      end else begin
        speech_set <= next_speech_set;
      end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        peak <= '0;
      end else begin
        peak <= next_peak;
      end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        slope_cnt <= SLOPE_START;
      end else begin
        slope_cnt <= next_slope_cnt;
      end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        talk_q <= 1'b0;
      end else begin
        talk_q <= next_talk;
      end
    end

    assign talk[ch] = talk_q;
    assign set[ch] = speech_set;
  end

  // decisions to the controller
  assign link.acoustic_talk = talk[CH_ACOUSTIC];
  assign link.line_talk = talk[CH_LINE];
  assign link.acoustic_speech_set = set[CH_ACOUSTIC];
  assign link.line_speech_set = set[CH_LINE];

  // decisions to the pins
  assign O_ACOUSTIC_TALK = talk[CH_ACOUSTIC];
  assign O_LINE_TALK = talk[CH_LINE];
  assign O_ACOUSTIC_SPEECH_SET = set[CH_ACOUSTIC];
  assign O_LINE_SPEECH_SET = set[CH_LINE];
endmodule : esc_dev

// File: esc_ctl.sv
// controller end: apb registers that program the comparators
`timescale 1ns/1ps
module esc_ctl (
  // link to the comparators
  esc_if.ctl link,
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [esc_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [esc_pkg::DATA_W-1:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [esc_pkg::DATA_W-1:0] O_PRDATA,
  // speech detectors
  input wire logic I_SPEECH_TX,
  input wire logic I_SPEECH_RX,
  // decisions for mode control
  output logic O_ACOUSTIC_TALK,
  output logic O_LINE_TALK
);
  import esc_pkg::*;

  logic [DATA_W-1:0] reg_ae_gains;
  logic [DATA_W-1:0] reg_ae_times;
  logic [DATA_W-1:0] reg_le_gains;
  logic [DATA_W-1:0] reg_le_times;
  logic speech_tx;
  logic speech_rx;

  wire setup = I_PSEL & ~I_PENABLE;
  wire wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  wire hit_aeg = (I_PADDR == REG_AE_GAINS);
  wire hit_aet = (I_PADDR == REG_AE_TIMES);
  wire hit_leg = (I_PADDR == REG_LE_GAINS);
  wire hit_let = (I_PADDR == REG_LE_TIMES);
  wire hit_st = (I_PADDR == REG_STATUS);
  wire hit = hit_aeg | hit_aet | hit_leg | hit_let | hit_st;

  wire [DATA_W-1:0] status = DATA_W'({link.speech_rx, link.speech_tx, link.line_speech_set,
                                      link.acoustic_speech_set, link.line_talk, link.acoustic_talk});
  wire [DATA_W-1:0] rd_mux = hit_aeg ? reg_ae_gains :
                             hit_aet ? reg_ae_times :
                             hit_leg ? reg_le_gains :
                             hit_let ? reg_le_times :
                             hit_st ? status : '0;

  // answer in the first access cycle
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= '0;
    end else begin
      O_PREADY <= setup;
      O_PSLVERR <= setup & ~hit;
      O_PRDATA <= (setup & ~I_PWRITE) ? rd_mux : '0;
    end
  end

  // identical speech and noise defaults give a single slope
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      reg_ae_gains <= AE_GAINS_RST;
      reg_ae_times <= AE_TIMES_RST;
      reg_le_gains <= LE_GAINS_RST;
      reg_le_times <= LE_TIMES_RST;
    end else begin
      if (wr & hit_aeg) reg_ae_gains <= I_PWDATA & GAINS_MASK;
      if (wr & hit_aet) reg_ae_times <= I_PWDATA & TIMES_MASK;
      if (wr & hit_leg) reg_le_gains <= I_PWDATA & GAINS_MASK;
      if (wr & hit_let) reg_le_times <= I_PWDATA & TIMES_MASK;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      speech_tx <= 1'b0;
      speech_rx <= 1'b0;
      O_ACOUSTIC_TALK <= 1'b0;
      O_LINE_TALK <= 1'b0;
    end else begin
      speech_tx <= I_SPEECH_TX;
      speech_rx <= I_SPEECH_RX;
      O_ACOUSTIC_TALK <= link.acoustic_talk;
      O_LINE_TALK <= link.line_talk;
    end
  end

  assign link.speech_tx = speech_tx;
  assign link.speech_rx = speech_rx;
  assign link.acoustic_echo_gain = reg_ae_gains[F_GAIN_LSB +: GAIN_W];
  assign link.acoustic_delta_gain_speech = reg_ae_gains[F_DS_LSB +: GAIN_W];
  assign link.acoustic_delta_gain_noise = reg_ae_gains[F_DN_LSB +: GAIN_W];
  assign link.acoustic_decay_slope_speech = reg_ae_times[F_SS_LSB +: SLOPE_W];
  assign link.acoustic_decay_slope_noise = reg_ae_times[F_SN_LSB +: SLOPE_W];
  assign link.acoustic_echo_hold_time = reg_ae_times[F_HOLD_LSB +: HOLD_W];
  assign link.line_echo_gain = reg_le_gains[F_GAIN_LSB +: GAIN_W];
  assign link.line_delta_gain_speech = reg_le_gains[F_DS_LSB +: GAIN_W];
  assign link.line_delta_gain_noise = reg_le_gains[F_DN_LSB +: GAIN_W];
  assign link.line_decay_slope_speech = reg_le_times[F_SS_LSB +: SLOPE_W];
  assign link.line_decay_slope_noise = reg_le_times[F_SN_LSB +: SLOPE_W];
  assign link.line_echo_hold_time = reg_le_times[F_HOLD_LSB +: HOLD_W];
endmodule : esc_ctl

// File: esc_chk.sv
// assertions on the link between the comparator end and its controller
`timescale 1ns/1ps
module esc_chk (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // link signals
  input wire esc_pkg::esc_hold_t acoustic_echo_hold_time,
  input wire esc_pkg::esc_hold_t line_echo_hold_time,
  input wire logic speech_tx,
  input wire logic speech_rx,
  input wire logic acoustic_speech_set,
  input wire logic line_speech_set
);
  import esc_pkg::*;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);

  chk_ae_set_follow: assert property (speech_tx |=> acoustic_speech_set)
    else $error("acoustic speech set missing during speech");
  chk_le_set_follow: assert property (speech_rx |=> line_speech_set)
    else $error("line speech set missing during speech");
  chk_ae_set_rise: assert property ($rose(acoustic_speech_set) |-> $past(speech_tx))
    else $error("acoustic speech set rose without near speech");
  chk_le_set_rise: assert property ($rose(line_speech_set) |-> $past(speech_rx))
    else $error("line speech set rose without far speech");
  chk_ae_set_fall: assert property ($fell(acoustic_speech_set) |-> !$past(speech_tx))
    else $error("acoustic speech set fell during speech");
  chk_le_set_fall: assert property ($fell(line_speech_set) |-> !$past(speech_rx))
    else $error("line speech set fell during speech");
  chk_ae_hold_keep: assert property ($fell(speech_tx) && acoustic_echo_hold_time != 16'h0000
    && $stable(acoustic_echo_hold_time) |=> acoustic_speech_set)
    else $error("acoustic speech set dropped before hold time");
  chk_le_hold_keep: assert property ($fell(speech_rx) && line_echo_hold_time != 16'h0000
    && $stable(line_echo_hold_time) |=> line_speech_set)
    else $error("line speech set dropped before hold time");
  chk_le_zero_hold: assert property ($fell(speech_rx) && line_echo_hold_time == 16'h0000
    && $stable(line_echo_hold_time) |=> !line_speech_set)
    else $error("line speech set kept with zero hold time");
endmodule : esc_chk

// File: tb_echo_speech_comparators.sv
// self-checking bench for the comparator end and its controller
`timescale 1ns/1ps
module tb_echo_speech_comparators;
  import esc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic [DATA_W-1:0] prdata;
  logic sp_tx = 1'b0;
  logic sp_rx = 1'b0;
  logic sv = 1'b0;
  esc_level_t spk = 8'h00;
  esc_level_t mic = 8'h00;
  esc_level_t snd = 8'h00;
  esc_level_t lin = 8'h00;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] d;
  logic e;
  logic ctl_ae_talk;
  logic ctl_le_talk;
  logic dev_ae_talk;
  logic dev_le_talk;
  logic dev_ae_set;
  logic dev_le_set;

  esc_if link();
  esc_ctl u_esc_ctl (.link(link), .I_CLOCK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PRDATA(prdata), .I_SPEECH_TX(sp_tx), .I_SPEECH_RX(sp_rx), .O_ACOUSTIC_TALK(ctl_ae_talk),
    .O_LINE_TALK(ctl_le_talk));
  esc_dev #(.TICK_CYCLES_P(4)) u_esc_dev (.link(link), .I_CLOCK(clk), .I_RST_B(rst_b),
    .I_SAMPLE_VALID(sv), .I_SPK_LEVEL(spk), .I_MIC_LEVEL(mic), .I_SEND_LEVEL(snd), .I_LINE_LEVEL(lin),
    .O_ACOUSTIC_TALK(dev_ae_talk), .O_LINE_TALK(dev_le_talk), .O_ACOUSTIC_SPEECH_SET(dev_ae_set),
    .O_LINE_SPEECH_SET(dev_le_set));
  esc_chk u_esc_chk (.I_CLOCK(clk), .I_RST_B(rst_b), .acoustic_echo_hold_time(link.acoustic_echo_hold_time),
    .line_echo_hold_time(link.line_echo_hold_time), .speech_tx(link.speech_tx), .speech_rx(link.speech_rx),
    .acoustic_speech_set(link.acoustic_speech_set), .line_speech_set(link.line_speech_set));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(d, exp);
  endtask : rdchk

  task automatic smp(input int ch, input esc_level_t r, input esc_level_t c, input logic exp);
    if (ch == CH_ACOUSTIC) begin
      spk <= r;
      mic <= c;
    end else begin
      snd <= r;
      lin <= c;
    end
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    @(posedge clk);
    chk({31'h0, ch == CH_ACOUSTIC ? link.acoustic_talk : link.line_talk}, {31'h0, exp});
    chk({31'h0, ch == CH_ACOUSTIC ? dev_ae_talk : dev_le_talk}, {31'h0, exp});
    @(posedge clk);
    chk({31'h0, ch == CH_ACOUSTIC ? ctl_ae_talk : ctl_le_talk}, {31'h0, exp});
  endtask : smp

  task automatic spd(input int ch, input logic v);
    if (ch == CH_ACOUSTIC) begin
      sp_tx <= v;
    end else begin
      sp_rx <= v;
    end
  endtask : spd

  function automatic logic sset(input int ch);
    return ch == CH_ACOUSTIC ? link.acoustic_speech_set : link.line_speech_set;
  endfunction : sset

  // speech set must outlast speech by h ticks of 4 clocks, restarted by new speech
  task automatic hold(input int ch, input logic [15:0] h);
    int n;
    apb(1'b1, ch == CH_ACOUSTIC ? REG_AE_TIMES : REG_LE_TIMES, {h, 16'h5555});
    spd(ch, 1'b1);
    repeat (3) @(posedge clk);
    spd(ch, 1'b0);
    if (h > 16'h0003) begin
      repeat (8) @(posedge clk);
      chk({31'h0, sset(ch)}, 32'h1);
      chk({31'h0, ch == CH_ACOUSTIC ? dev_ae_set : dev_le_set}, 32'h1);
      spd(ch, 1'b1);
      @(posedge clk);
      spd(ch, 1'b0);
    end
    n = 0;
    while (sset(ch) === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= 4 * h && n <= 4 * h + 8}, 32'h1);
  endtask : hold

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdchk(REG_AE_GAINS, AE_GAINS_RST);
    rdchk(REG_AE_TIMES, AE_TIMES_RST);
    rdchk(REG_LE_GAINS, LE_GAINS_RST);
    rdchk(REG_LE_TIMES, LE_TIMES_RST);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    $display("test registers done");
    apb(1'b1, REG_AE_GAINS, 32'hFF001400);
    rdchk(REG_AE_GAINS, 32'h00001400);
    smp(CH_ACOUSTIC, 8'h28, 8'h2D, 1'b1);
    sp_tx <= 1'b1;
    repeat (3) @(posedge clk);
    smp(CH_ACOUSTIC, 8'h28, 8'h2D, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(d & 32'h00000014, 32'h00000014);
    $display("test speech set done");
    hold(CH_ACOUSTIC, 16'h0005);
    hold(CH_LINE, 16'h0003);
    hold(CH_LINE, 16'h0000);
    $display("test echo hold done");
    apb(1'b1, REG_LE_TIMES, 32'h00000202);
    sp_rx <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, dev_le_set}, 32'h1);
    smp(CH_LINE, 8'h64, 8'h67, 1'b1);
    sp_rx <= 1'b0;
    smp(CH_LINE, 8'h64, 8'h66, 1'b0);
    smp(CH_LINE, 8'h00, 8'h65, 1'b0);
    repeat (100) @(posedge clk);
    smp(CH_LINE, 8'h00, 8'h65, 1'b1);
    $display("test line decay done");
    print_verdict();
  end
endmodule : tb_echo_speech_comparators
